// *** pkg/sctx_pkg.sv ***
package sctx_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] HOLD_OFS = 8'h08;
  localparam logic [7:0] DIV_OFS = 8'h0c;
  localparam logic [7:0] ISTAT_OFS = 8'h10;
  localparam logic [7:0] IMASK_OFS = 8'h14;
  localparam int CTRL_TE_BIT = 0;
  localparam int CTRL_RIE_BIT = 1;
  localparam int CTRL_TIE_BIT = 2;
  localparam int ST_ERS_BIT = 0;
  localparam int ST_TRANSMIT_END_FLAG_BIT = 1;
  localparam int ST_HOLDING_EMPTY_FLAG_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int EV_ERS_BIT = 0;
  localparam int EV_TRANSMIT_END_FLAG_BIT = 1;
  localparam logic [7:0] DIV_RESET = 8'h01;
  localparam logic [8:0] BIT_FACTOR = 9'h174;
  localparam int FRAME_BITS = 11;
  localparam logic [3:0] ERR_BIT_POS = 4'hb;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic transmit_irq_enable;
    logic receive_irq_enable;
    logic tx_en;
  } sctx_ctrl_s;

  typedef struct packed {
    logic busy;
    logic holding_empty_flag;
    logic transmit_end_flag;
    logic error_signal_flag;
  } sctx_stat_s;
endpackage

// *** src/sctx_baud.sv ***
`timescale 1ns/1ps
module sctx_baud (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [7:0] bit_rate_divisor,
  output logic tick
);
  logic [8:0] fcnt;
  logic [7:0] dcnt;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      fcnt <= 9'h000;
      dcnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (fcnt == sctx_pkg::BIT_FACTOR - 9'h001) begin
        fcnt <= 9'h000;
        if (dcnt == bit_rate_divisor) begin
          dcnt <= 8'h00;
          tick <= 1'b1;
        end else begin
          dcnt <= dcnt + 8'h01;
        end
      end else begin
        fcnt <= fcnt + 9'h001;
      end
    end
  end
endmodule

// *** src/sctx_irq.sv ***
`timescale 1ns/1ps
module sctx_irq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] event_set,
  input wire logic [1:0] w1c,
  input wire logic [1:0] mask_wr_en,
  input wire logic [1:0] mask_wr_data,
  output logic [1:0] status,
  output logic [1:0] mask,
  output logic irq
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 2'h0;
    end else begin
      status <= (status & ~w1c) | event_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= 2'h0;
    end else if (mask_wr_en[0]) begin
      mask <= mask_wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~w1c) | event_set) & mask);
    end
  end
endmodule

// *** src/sctx_top.sv ***
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Error signal after frame sets error flag
// - Error flag with receive enable raises irq
// - Errored frame never sets transmit end
// - Errored frame reloads holding byte, resends automatically
// - No error signal leaves error flag alone
// - Successful frame sets transmit end flag
// - Transmit end with enable raises empty irq
// - Holding write after completion starts next byte
// - Holding empty set together with transmit end
// - Empty request drives DMA activation
// - DMA write clears holding empty, transmit end
// - Transmit end held low during retransmission
// - Hardware never clears error flag itself
// - Bit period is 372 clocks times (divisor + 1)
module sctx_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dma_wr,
  input wire logic [7:0] dma_data,
  input wire logic rx_line,
  output logic tx_line,
  output logic tx_oe_n,
  output logic receive_error_irq,
  output logic transmit_empty_irq,
  output logic irq
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_GUARD = 3'b100
  } sctx_state_e;

  sctx_state_e state;
  sctx_pkg::sctx_ctrl_s serial_control_reg;
  sctx_pkg::sctx_stat_s serial_status_reg;
  logic [7:0] transmit_holding_reg;
  logic [10:0] transmit_shift_reg;
  logic [7:0] bit_rate_divisor;
  logic [3:0] bit_cnt;
  logic ers_seen_one;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic tick;
  logic wr_fire;
  logic sw_hold_wr;
  logic load;
  logic frame_err;
  logic frame_ok;
  logic [1:0] ev_status;
  logic [1:0] ev_mask;
  logic [1:0] w1c;
  logic mask_we;
  logic addr_ok;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = hit(a, sctx_pkg::CTRL_OFS) || hit(a, sctx_pkg::STAT_OFS) ||
            hit(a, sctx_pkg::HOLD_OFS) || hit(a, sctx_pkg::DIV_OFS) ||
            hit(a, sctx_pkg::ISTAT_OFS) || hit(a, sctx_pkg::IMASK_OFS);
  endfunction

  // Write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold <= 1'b0;
      end
    end
  end

  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  assign addr_ok = known(aw_addr);
  assign sw_hold_wr = wr_fire && hit(aw_addr, sctx_pkg::HOLD_OFS) && w_strb[0];
  assign w1c = (wr_fire && hit(aw_addr, sctx_pkg::ISTAT_OFS) && w_strb[0]) ?
               w_data[1:0] : 2'h0;
  assign mask_we = wr_fire && hit(aw_addr, sctx_pkg::IMASK_OFS) && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sctx_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_hold && !(s_axi_wvalid && s_axi_wready);
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok ? sctx_pkg::RESP_OKAY : sctx_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= sctx_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= known(s_axi_araddr) ? sctx_pkg::RESP_OKAY :
                       sctx_pkg::RESP_SLVERR;
        s_axi_rdata <= 32'h0;
        if (hit(s_axi_araddr, sctx_pkg::CTRL_OFS)) begin
          s_axi_rdata[2:0] <= serial_control_reg;
        end
        if (hit(s_axi_araddr, sctx_pkg::STAT_OFS)) begin
          s_axi_rdata[3:0] <= serial_status_reg;
        end
        if (hit(s_axi_araddr, sctx_pkg::HOLD_OFS)) begin
          s_axi_rdata[7:0] <= transmit_holding_reg;
        end
        if (hit(s_axi_araddr, sctx_pkg::DIV_OFS)) begin
          s_axi_rdata[7:0] <= bit_rate_divisor;
        end
        if (hit(s_axi_araddr, sctx_pkg::ISTAT_OFS)) begin
          s_axi_rdata[1:0] <= ev_status;
        end
        if (hit(s_axi_araddr, sctx_pkg::IMASK_OFS)) begin
          s_axi_rdata[1:0] <= ev_mask;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control and divisor registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_control_reg <= '0;
      bit_rate_divisor <= sctx_pkg::DIV_RESET;
    end else if (wr_fire && w_strb[0]) begin
      if (hit(aw_addr, sctx_pkg::CTRL_OFS)) begin
        serial_control_reg <= w_data[2:0];
      end
      if (hit(aw_addr, sctx_pkg::DIV_OFS)) begin
        bit_rate_divisor <= w_data[7:0];
      end
    end
  end

  // Holding register fed by software or DMA
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_holding_reg <= 8'h00;
    end else if (dma_wr) begin
      transmit_holding_reg <= dma_data;
    end else if (sw_hold_wr) begin
      transmit_holding_reg <= w_data[7:0];
    end
  end

  assign load = (state == ST_IDLE) && serial_control_reg.tx_en &&
                !serial_status_reg.holding_empty_flag;
  assign frame_err = (state == ST_GUARD) && tick && !rx_line;
  assign frame_ok = (state == ST_GUARD) && tick && rx_line;

  sctx_baud u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .run((state != ST_IDLE) || load),
    .bit_rate_divisor(bit_rate_divisor),
    .tick(tick)
  );

  // Frame sequencer: start, 8 data, parity, then error sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      transmit_shift_reg <= 11'h7ff;
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (load) begin
            transmit_shift_reg <= {1'b1, ^transmit_holding_reg,
                                   transmit_holding_reg, 1'b0};
            bit_cnt <= 4'h0;
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tick) begin
            transmit_shift_reg <= {1'b1, transmit_shift_reg[10:1]};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == sctx_pkg::ERR_BIT_POS - 4'h2) begin
              state <= ST_GUARD;
            end
          end
        end
        ST_GUARD: begin
          if (frame_err) begin
            transmit_shift_reg <= {1'b1, ^transmit_holding_reg,
                                   transmit_holding_reg, 1'b0};
            bit_cnt <= 4'h0;
            state <= ST_SEND;
          end else if (frame_ok) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_line <= 1'b1;
      tx_oe_n <= 1'b1;
    end else begin
      tx_line <= (state == ST_SEND) ? transmit_shift_reg[0] : 1'b1;
      tx_oe_n <= (state != ST_SEND);
    end
  end

  // Status flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_status_reg <= 4'b0110;
      ers_seen_one <= 1'b0;
    end else begin
      serial_status_reg.busy <= (state != ST_IDLE) || load;
      if (s_axi_arvalid && s_axi_arready &&
          hit(s_axi_araddr, sctx_pkg::STAT_OFS)) begin
        ers_seen_one <= serial_status_reg.error_signal_flag;
      end
      if (frame_err) begin
        serial_status_reg.error_signal_flag <= 1'b1;
      end else if (wr_fire && hit(aw_addr, sctx_pkg::STAT_OFS) && w_strb[0] &&
                   !w_data[0] && ers_seen_one) begin
        serial_status_reg.error_signal_flag <= 1'b0;
        ers_seen_one <= 1'b0;
      end
      if (frame_ok) begin
        serial_status_reg.transmit_end_flag <= 1'b1;
        serial_status_reg.holding_empty_flag <= 1'b1;
      end else if (dma_wr || sw_hold_wr) begin
        serial_status_reg.transmit_end_flag <= 1'b0;
        serial_status_reg.holding_empty_flag <= 1'b0;
      end
    end
  end

  sctx_irq u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_set({frame_ok, frame_err}),
    .w1c(w1c),
    .mask_wr_en({1'b0, mask_we}),
    .mask_wr_data(w_data[1:0]),
    .status(ev_status),
    .mask(ev_mask),
    .irq(irq)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_error_irq <= 1'b0;
      transmit_empty_irq <= 1'b0;
    end else begin
      receive_error_irq <= serial_control_reg.receive_irq_enable &&
                           (serial_status_reg.error_signal_flag ||
                            frame_err);
      transmit_empty_irq <= serial_control_reg.transmit_irq_enable &&
                            serial_status_reg.transmit_end_flag &&
                            !dma_wr && !sw_hold_wr;
    end
  end

  property p_err_sets_flag;
    @(posedge aclk) disable iff (!aresetn)
      frame_err |=> serial_status_reg.error_signal_flag;
  endproperty
  a_err_sets_flag: assert property (p_err_sets_flag)
    else $error("error flag not set after error signal");

  property p_err_no_transmit_end_flag;
    @(posedge aclk) disable iff (!aresetn)
      frame_err |=> !serial_status_reg.transmit_end_flag && state == ST_SEND;
  endproperty
  a_err_no_transmit_end_flag: assert property (p_err_no_transmit_end_flag)
    else $error("transmit end set or no resend on error");

  property p_ok_sets_both;
    @(posedge aclk) disable iff (!aresetn)
      frame_ok |=> serial_status_reg.transmit_end_flag &&
                   serial_status_reg.holding_empty_flag;
  endproperty
  a_ok_sets_both: assert property (p_ok_sets_both)
    else $error("end and empty flags not set together");

  property p_dma_clears;
    @(posedge aclk) disable iff (!aresetn)
      (dma_wr && !frame_ok) |=> !serial_status_reg.transmit_end_flag &&
                                !serial_status_reg.holding_empty_flag;
  endproperty
  a_dma_clears: assert property (p_dma_clears)
    else $error("dma write did not clear flags");

  property p_txi;
    @(posedge aclk) disable iff (!aresetn)
      (frame_ok && serial_control_reg.transmit_irq_enable) ##1
      (!dma_wr && !sw_hold_wr) |=> transmit_empty_irq;
  endproperty
  a_txi: assert property (p_txi)
    else $error("transmit empty irq missing");

  property p_eri;
    @(posedge aclk) disable iff (!aresetn)
      (frame_err && serial_control_reg.receive_irq_enable) |=>
      receive_error_irq;
  endproperty
  a_eri: assert property (p_eri)
    else $error("receive error irq missing");

  property p_ers_sticky;
    @(posedge aclk) disable iff (!aresetn)
      (serial_status_reg.error_signal_flag && !wr_fire) |=>
      serial_status_reg.error_signal_flag;
  endproperty
  a_ers_sticky: assert property (p_ers_sticky)
    else $error("error flag cleared by hardware");

  property p_no_spurious_ers;
    @(posedge aclk) disable iff (!aresetn)
      (!serial_status_reg.error_signal_flag && !frame_err) |=>
      !serial_status_reg.error_signal_flag;
  endproperty
  a_no_spurious_ers: assert property (p_no_spurious_ers)
    else $error("error flag set without error signal");

  property p_start;
    @(posedge aclk) disable iff (!aresetn)
      load |=> state == ST_SEND ##1 !tx_oe_n;
  endproperty
  a_start: assert property (p_start)
    else $error("frame did not start after holding write");
endmodule

// *** verif/sctx_card_model.sv ***
`timescale 1ns/1ps
module sctx_card_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_line,
  input wire logic [15:0] slot,
  input wire logic [7:0] nak_until,
  output logic rx_line,
  output logic [7:0] frames,
  output logic [7:0] last_byte,
  output logic parity_ok,
  output logic [15:0] start_len
);
  logic [15:0] sc;
  logic [3:0] k;
  logic [9:0] sh;
  logic act;
  logic nak_now;
  logic prev_tx;
  logic run_lo;
  // Frame starts on a falling line; a resend may begin after the sample slot
  always_ff @(posedge aclk) begin
    prev_tx <= tx_line;
    if (!aresetn) begin
      act <= 1'b0;
      frames <= 8'h00;
      rx_line <= 1'b1;
      run_lo <= 1'b0;
    end else if (prev_tx && !tx_line && (!act || k > 4'h9)) begin
      act <= 1'b1;
      sc <= 16'h0001;
      k <= 4'h0;
      rx_line <= 1'b1;
      run_lo <= 1'b1;
      start_len <= 16'h0001;
    end else if (act) begin
      if (run_lo && !tx_line) begin
        start_len <= start_len + 16'h0001;
      end else begin
        run_lo <= 1'b0;
      end
      sc <= (sc == slot) ? 16'h0001 : sc + 16'h0001;
      if (sc == slot) begin
        k <= k + 4'h1;
      end
      if (sc == slot >> 1) begin
        if (k < 4'h9) begin
          sh <= {tx_line, sh[9:1]};
        end
        if (k == 4'h9) begin
          frames <= frames + 8'h01;
          last_byte <= sh[9:2];
          parity_ok <= ~^{tx_line, sh[9:2]};
          nak_now <= frames < nak_until;
        end
        // Error signal driven low across the sample slot, then released
        if (k == 4'ha && nak_now) begin
          rx_line <= 1'b0;
        end
        if (k == 4'hc) begin
          rx_line <= 1'b1;
          act <= 1'b0;
        end
      end
    end
  end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, br;
  logic [31:0] s_axi_rdata, rd;
  logic dma_wr = 1'b0;
  logic [7:0] dma_data = 8'h00;
  logic rx_line, tx_line, tx_oe_n, receive_error_irq, transmit_empty_irq;
  logic irq, parity_ok;
  logic [7:0] nak_until = 8'h00;
  logic [7:0] frames, last_byte, n;
  logic [15:0] start_len;
  int bad_count = 0;
  int compares = 0;

  sctx_top i_sctx_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .dma_wr(dma_wr), .dma_data(dma_data),
    .rx_line(rx_line), .tx_line(tx_line), .tx_oe_n(tx_oe_n),
    .receive_error_irq(receive_error_irq),
    .transmit_empty_irq(transmit_empty_irq), .irq(irq)
  );

  sctx_card_model i_sctx_card_model (
    .aclk(aclk), .aresetn(aresetn), .tx_line(tx_line),
    .slot(16'd372), .nak_until(nak_until), .rx_line(rx_line),
    .frames(frames), .last_byte(last_byte), .parity_ok(parity_ok),
    .start_len(start_len)
  );

  initial forever #5 aclk = ~aclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    br = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Wait for frame number m at the card, then until the unit is idle
  task automatic settle(input logic [7:0] m);
    @(posedge aclk iff frames == m);
    do rdr(sctx_pkg::STAT_OFS);
    while (rd[3] !== 1'b0);
  endtask

  task automatic t_reset();
    chk(tx_line, 1'b1);
    chk(tx_oe_n, 1'b1);
    rdr(sctx_pkg::STAT_OFS);
    chk(rd, 32'h6);
    rdr(sctx_pkg::DIV_OFS);
    chk(rd, 32'h1);
    rdr(8'hfc);
    chk(br, sctx_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'hfc, 32'h1);
    chk(br, sctx_pkg::RESP_SLVERR);
    $display("reset test done");
  endtask

  task automatic t_good();
    wr(sctx_pkg::DIV_OFS, 32'h0);
    wr(sctx_pkg::CTRL_OFS, 32'h7);
    n = frames + 8'h01;
    wr(sctx_pkg::HOLD_OFS, 32'ha5);
    settle(n);
    chk(rd, 32'h6);
    chk(last_byte, 8'ha5);
    chk(parity_ok, 1'b1);
    chk(start_len, 16'd372);
    chk(transmit_empty_irq, 1'b1);
    chk(receive_error_irq, 1'b0);
    rdr(sctx_pkg::ISTAT_OFS);
    chk(rd, 32'h2);
    chk(irq, 1'b0);
    wr(sctx_pkg::IMASK_OFS, 32'h3);
    chk(irq, 1'b1);
    wr(sctx_pkg::IMASK_OFS, 32'h0);
    chk(irq, 1'b0);
    wr(sctx_pkg::IMASK_OFS, 32'h3);
    chk(irq, 1'b1);
    wr(sctx_pkg::ISTAT_OFS, 32'h2);
    chk(irq, 1'b0);
    wr(sctx_pkg::CTRL_OFS, 32'h3);
    chk(transmit_empty_irq, 1'b0);
    wr(sctx_pkg::CTRL_OFS, 32'h7);
    $display("good frame test done");
  endtask

  task automatic t_err();
    n = frames + 8'h01;
    nak_until <= n;
    wr(sctx_pkg::HOLD_OFS, 32'h3c);
    @(posedge aclk iff receive_error_irq);
    chk(transmit_empty_irq, 1'b0);
    rdr(sctx_pkg::STAT_OFS);
    chk(rd[1:0], 2'h1);
    wr(sctx_pkg::CTRL_OFS, 32'h5);
    chk(receive_error_irq, 1'b0);
    wr(sctx_pkg::CTRL_OFS, 32'h7);
    chk(receive_error_irq, 1'b1);
    wr(sctx_pkg::STAT_OFS, 32'h1);
    rdr(sctx_pkg::STAT_OFS);
    chk(rd[0], 1'b1);
    wr(sctx_pkg::STAT_OFS, 32'h0);
    rdr(sctx_pkg::STAT_OFS);
    chk(rd[1:0], 2'h0);
    settle(n + 8'h01);
    chk(rd, 32'h6);
    chk(last_byte, 8'h3c);
    rdr(sctx_pkg::ISTAT_OFS);
    chk(rd, 32'h3);
    wr(sctx_pkg::ISTAT_OFS, 32'h3);
    $display("error resend test done");
  endtask

  task automatic t_dma();
    logic [7:0] d [2];
    d[0] = 8'h81;
    d[1] = 8'h42;
    for (int i = 0; i < 2; i++) begin
      n = frames + 8'h01;
      @(posedge aclk iff transmit_empty_irq);
      dma_data <= d[i];
      dma_wr <= 1'b1;
      @(posedge aclk);
      dma_wr <= 1'b0;
      rdr(sctx_pkg::STAT_OFS);
      chk(rd[2:1], 2'h0);
      chk(transmit_empty_irq, 1'b0);
      chk(tx_oe_n, 1'b0);
      @(posedge aclk iff frames == n);
      chk(last_byte, d[i]);
    end
    settle(n);
    chk(rd, 32'h6);
    $display("dma test done");
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #600000;
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_good();
    t_err();
    t_dma();
    wrap_up();
  end
endmodule
